// ### vcb_pkg.sv
// package: register map, field positions and timing for the csr control bank
package vcb_pkg;
  localparam logic [11:0] OFF_USER_PULSE_SET = 12'h7e8;
  localparam logic [11:0] OFF_USER_PULSE_CLEAR = 12'h7ec;
  localparam logic [11:0] OFF_CONFIG_RAM_HOLDER = 12'h7f0;
  localparam logic [11:0] OFF_STANDARD_BIT_CLEAR = 12'h7f4;
  localparam logic [11:0] OFF_STANDARD_BIT_SET = 12'h7f8;
  localparam logic [11:0] OFF_CONFIG_SPACE_BASE = 12'h7fc;
  localparam logic [11:0] OFF_FUNCTION_COMPARE = 12'h79c;
  localparam int USER_LSB = 24;
  localparam int HOLDER_LSB = 24;
  localparam int BIT_LOCAL_RESET = 31;
  localparam int BIT_FAIL_DRIVE = 30;
  localparam int BIT_MODULE_EN = 28;
  localparam int BIT_BUS_FAULT = 27;
  localparam int BIT_HOLDER = 26;
  localparam int BASE_LSB = 27;
  localparam int CMP_LSB = 8;
  localparam int AM_LSB = 2;
  localparam int BIT_DYN_READ = 1;
  localparam int BIT_EXT_MOD = 0;
  localparam logic [7:0] HOLDER_RESET = 8'h00;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int LOCAL_RESET_MIN_MS = 200;
  localparam int LOCAL_RESET_CYCLES =
    (LOCAL_RESET_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } vcb_req_t;
endpackage : vcb_pkg

// ### vcb_hold_timer.sv
// minimum-hold timer for the local reset output
`timescale 1ns/1ns
module vcb_hold_timer #(
  parameter int CYCLES = 20000000
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  output logic done
);
  if (CYCLES < 2) begin : g_bad_cycles
    $error("hold timer needs at least two cycles");
  end
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt_q;

  // reloads on start, counts down to zero; done while zero and start is low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else if (start) begin
      cnt_q <= W'(CYCLES - 1);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
  assign done = (cnt_q == '0) && !start;
endmodule : vcb_hold_timer

// ### vcb_bank.sv
// csr control bank: set/clear bits, holder semaphore, base and compare regs
`timescale 1ns/1ns
//
// Overview of operation
// - dyn read write latches mask into shadow
// - dyn read set: compare reads show shadow
// - no dynamic sizing: dyn read bit ignored; write loads compare bits
// - extended modifier bit reads zero, read-only
// - fixed address flag freezes compare bits
// - user set write pulses set event; reads status
// - user clear write pulses clear event; reads status
// - holder field writable only while zero
// - holder release bit zeroes holder; reads owned
// - holder taken bit read-only, shows owned
// - set/clear bit 31 drives local reset
// - local reset held at least 200 ms
// - set/clear bit 30 drives fail line
// - set/clear bit 28 enables slave windows
// - bus fault bit set by BERR, set/clear
// - base field loads from geographic pins on the first clock after reset
// - board selected when base equals address 23:19
module vcb_bank
  import vcb_pkg::*;
#(
  parameter int HOLD_CYCLES = LOCAL_RESET_CYCLES,
  parameter bit DYN_SIZING = 1'b1
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire vcb_pkg::vcb_req_t REQ,
  output logic [31:0] RDATA,
  input wire logic [7:0] USER_STATUS,
  output logic [7:0] USER_SET_EVENT,
  output logic [7:0] USER_CLEAR_EVENT,
  input wire logic [4:0] GEO_ADDR_N,
  input wire logic [31:8] SLAVE_WINDOW_MASK,
  input wire logic FIXED_ADDRESS_FLAG,
  input wire logic BERR_DRIVEN,
  input wire logic [23:19] BACKPLANE_ADDRESS_LINES,
  output logic LOCAL_RESET_N,
  output logic FAIL_LINE_DRIVE_OUT,
  output logic MODULE_ENABLED,
  output logic BOARD_SELECTED
);
  import vcb_pkg::*;

  if (HOLD_CYCLES < 2) begin : g_bad_hold
    $error("HOLD_CYCLES must be at least 2");
  end

  function automatic logic hit(input vcb_req_t r, input logic [11:0] off);
    hit = r.wr && (r.addr == off);
  endfunction : hit

  logic w_uset, w_uclr, w_hold, w_bclr, w_bset, w_base, w_cmp;
  assign w_uset = hit(REQ, OFF_USER_PULSE_SET);
  assign w_uclr = hit(REQ, OFF_USER_PULSE_CLEAR);
  assign w_hold = hit(REQ, OFF_CONFIG_RAM_HOLDER);
  assign w_bclr = hit(REQ, OFF_STANDARD_BIT_CLEAR);
  assign w_bset = hit(REQ, OFF_STANDARD_BIT_SET);
  assign w_base = hit(REQ, OFF_CONFIG_SPACE_BASE);
  assign w_cmp = hit(REQ, OFF_FUNCTION_COMPARE);

  ////////////////////////////////////////////////////////////////////////////
  // user pulse registers
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      USER_SET_EVENT <= 8'h00;
      USER_CLEAR_EVENT <= 8'h00;
    end else begin
      USER_SET_EVENT <= w_uset ? REQ.wdata[31:24] : 8'h00;
      USER_CLEAR_EVENT <= w_uclr ? REQ.wdata[31:24] : 8'h00;
    end
  end
  a_user_set_pulse: assert property (
    @(posedge CLK) disable iff (!RESETN)
    w_uset |=> USER_SET_EVENT == $past(REQ.wdata[31:24]))
    else $error("user set event does not match write");
  a_user_clr_once: assert property (
    @(posedge CLK) disable iff (!RESETN)
    !w_uclr |=> USER_CLEAR_EVENT == 8'h00)
    else $error("user clear event without write");

  ////////////////////////////////////////////////////////////////////////////
  // holder semaphore
  logic [7:0] holder_q;
  logic owned;
  assign owned = holder_q != 8'h00;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      holder_q <= HOLDER_RESET;
    end else if (w_bclr && REQ.wdata[BIT_HOLDER]) begin
      holder_q <= 8'h00;
    end else if (w_hold && !owned) begin
      holder_q <= REQ.wdata[31:24];
    end
  end
  a_holder_locked: assert property (
    @(posedge CLK) disable iff (!RESETN)
    owned && !(w_bclr && REQ.wdata[BIT_HOLDER]) |=> $stable(holder_q))
    else $error("holder changed while owned");
  a_holder_release: assert property (
    @(posedge CLK) disable iff (!RESETN)
    w_bclr && REQ.wdata[BIT_HOLDER] |=> holder_q == 8'h00)
    else $error("holder not released");

  ////////////////////////////////////////////////////////////////////////////
  // local reset with minimum hold
  logic lreset_n_q, lreset_q, hold_done;
  logic lreset_start;
  assign lreset_q = !lreset_n_q;
  assign lreset_start = w_bset && REQ.wdata[BIT_LOCAL_RESET] && !lreset_q;
  vcb_hold_timer #(.CYCLES(HOLD_CYCLES)) u_hold (
    .clk(CLK),
    .resetn(RESETN),
    .start(lreset_start),
    .done(hold_done)
  );
  // a release request before the hold time expires is dropped
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      lreset_n_q <= 1'b1;
    end else if (w_bset && REQ.wdata[BIT_LOCAL_RESET]) begin
      lreset_n_q <= 1'b0;
    end else if (w_bclr && REQ.wdata[BIT_LOCAL_RESET] && hold_done) begin
      lreset_n_q <= 1'b1;
    end
  end
  assign LOCAL_RESET_N = lreset_n_q;

  // cycles the local reset has stood, saturating at the hold time
  int lreset_age_q;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      lreset_age_q <= 0;
    end else if (!lreset_q) begin
      lreset_age_q <= 0;
    end else if (lreset_age_q < HOLD_CYCLES) begin
      lreset_age_q <= lreset_age_q + 1;
    end
  end
  a_reset_drive: assert property (
    @(posedge CLK) disable iff (!RESETN)
    w_bset && REQ.wdata[BIT_LOCAL_RESET] |=> !LOCAL_RESET_N)
    else $error("local reset not asserted");
  a_reset_hold_min: assert property (
    @(posedge CLK) disable iff (!RESETN)
    $rose(LOCAL_RESET_N) |-> lreset_age_q >= HOLD_CYCLES)
    else $error("local reset released too early");

  ////////////////////////////////////////////////////////////////////////////
  // fail drive, module enable, bus fault
  logic fail_q, modeb_q, fault_q;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      fail_q <= 1'b0;
    end else if (w_bset && REQ.wdata[BIT_FAIL_DRIVE]) begin
      fail_q <= 1'b1;
    end else if (w_bclr && REQ.wdata[BIT_FAIL_DRIVE]) begin
      fail_q <= 1'b0;
    end
  end
  assign FAIL_LINE_DRIVE_OUT = fail_q;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      modeb_q <= 1'b0;
    end else if (w_bset && REQ.wdata[BIT_MODULE_EN]) begin
      modeb_q <= 1'b1;
    end else if (w_bclr && REQ.wdata[BIT_MODULE_EN]) begin
      modeb_q <= 1'b0;
    end
  end
  assign MODULE_ENABLED = modeb_q;

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      fault_q <= 1'b0;
    end else if (BERR_DRIVEN || (w_bset && REQ.wdata[BIT_BUS_FAULT])) begin
      fault_q <= 1'b1;
    end else if (w_bclr && REQ.wdata[BIT_BUS_FAULT]) begin
      fault_q <= 1'b0;
    end
  end
  a_fault_sticky: assert property (
    @(posedge CLK) disable iff (!RESETN)
    BERR_DRIVEN |=> fault_q)
    else $error("bus fault not captured");

  ////////////////////////////////////////////////////////////////////////////
  // base register and board select
  logic [4:0] base_q;
  logic base_loaded_q;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      base_q <= 5'h00;
      base_loaded_q <= 1'b0;
    end else begin
      base_loaded_q <= 1'b1;
      if (!base_loaded_q) begin
        base_q <= ~GEO_ADDR_N;
      end else if (w_base) begin
        base_q <= REQ.wdata[31:27];
      end
    end
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      BOARD_SELECTED <= 1'b0;
    end else begin
      BOARD_SELECTED <= base_loaded_q &&
                        (BACKPLANE_ADDRESS_LINES == base_q);
    end
  end
  a_board_match: assert property (
    @(posedge CLK) disable iff (!RESETN)
    base_loaded_q && BACKPLANE_ADDRESS_LINES == base_q |=> BOARD_SELECTED)
    else $error("board select missed");

  ////////////////////////////////////////////////////////////////////////////
  // function compare register with mask shadow
  logic [31:8] cmp_q, shadow_q;
  logic dyn_q;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cmp_q <= REG_RESET[31:8];
    end else if (w_cmp && !FIXED_ADDRESS_FLAG &&
                 !(DYN_SIZING && REQ.wdata[BIT_DYN_READ])) begin
      // a mask latch write leaves the stored compare bits alone
      cmp_q <= REQ.wdata[31:8];
    end
  end
  a_fixed_freeze: assert property (
    @(posedge CLK) disable iff (!RESETN)
    FIXED_ADDRESS_FLAG |=> $stable(cmp_q))
    else $error("compare changed while fixed");
  a_dyn_keeps_cmp: assert property (
    @(posedge CLK) disable iff (!RESETN)
    w_cmp && DYN_SIZING && REQ.wdata[BIT_DYN_READ] |=>
      $stable(cmp_q) && shadow_q == $past(SLAVE_WINDOW_MASK))
    else $error("mask latch disturbed compare bits");
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      dyn_q <= 1'b0;
      shadow_q <= REG_RESET[31:8];
    end else if (w_cmp && DYN_SIZING) begin
      dyn_q <= REQ.wdata[BIT_DYN_READ];
      if (REQ.wdata[BIT_DYN_READ]) begin
        shadow_q <= SLAVE_WINDOW_MASK;
      end
    end
  end
  a_no_dyn_latch: assert property (
    @(posedge CLK) disable iff (!RESETN)
    !DYN_SIZING |=> !dyn_q && $stable(shadow_q))
    else $error("shadow latched without dynamic sizing");

  ////////////////////////////////////////////////////////////////////////////
  // read mux, registered; unmapped and reserved bits read zero
  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h0000_0000;
    case (REQ.addr)
      OFF_USER_PULSE_SET, OFF_USER_PULSE_CLEAR: begin
        rd_d[31:24] = USER_STATUS;
      end
      OFF_CONFIG_RAM_HOLDER: begin
        rd_d[31:24] = holder_q;
      end
      OFF_STANDARD_BIT_CLEAR, OFF_STANDARD_BIT_SET: begin
        rd_d[BIT_LOCAL_RESET] = lreset_q;
        rd_d[BIT_FAIL_DRIVE] = fail_q;
        rd_d[BIT_MODULE_EN] = modeb_q;
        rd_d[BIT_BUS_FAULT] = fault_q;
        rd_d[BIT_HOLDER] = owned;
      end
      OFF_CONFIG_SPACE_BASE: begin
        rd_d[31:27] = base_q;
      end
      OFF_FUNCTION_COMPARE: begin
        rd_d[31:8] = dyn_q ? shadow_q : cmp_q;
        rd_d[BIT_DYN_READ] = dyn_q;
        rd_d[BIT_EXT_MOD] = 1'b0;
      end
      default: begin
        rd_d = 32'h0000_0000;
      end
    endcase
  end
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      RDATA <= 32'h0000_0000;
    end else if (REQ.rd) begin
      RDATA <= rd_d;
    end
  end

endmodule : vcb_bank

// ### vcb_user_model.sv
// user-side logic model: status bits follow the set and clear events
`timescale 1ns/1ns
module vcb_user_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] set_ev,
  input wire logic [7:0] clr_ev,
  output logic [7:0] status
);
  // a set event raises the bit, a clear event drops it, clear last
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status <= 8'h00;
    end else begin
      status <= (status | set_ev) & ~clr_ev;
    end
  end
endmodule : vcb_user_model

// ### tb_top.sv
// self-checking testbench for the csr control bank
`timescale 1ns/1ns
module tb_top;
  import vcb_pkg::*;
  logic clk, resetn, fixed, berr, lrst_n, fail, men, bsel;
  vcb_req_t req;
  logic [31:0] rdata, rdata2, d;
  logic [7:0] st, sev, cev, b, h, ust;
  logic [4:0] geo;
  logic [31:8] mask;
  logic [23:19] bal;
  logic [23:0] c;
  int error_cnt, samples_checked;
  vcb_bank #(.HOLD_CYCLES(16), .DYN_SIZING(1'b1)) u_dut (.CLK(clk),
    .RESETN(resetn), .REQ(req), .RDATA(rdata), .USER_STATUS(st),
    .USER_SET_EVENT(sev), .USER_CLEAR_EVENT(cev), .GEO_ADDR_N(geo),
    .SLAVE_WINDOW_MASK(mask), .FIXED_ADDRESS_FLAG(fixed),
    .BERR_DRIVEN(berr), .BACKPLANE_ADDRESS_LINES(bal),
    .LOCAL_RESET_N(lrst_n), .FAIL_LINE_DRIVE_OUT(fail),
    .MODULE_ENABLED(men), .BOARD_SELECTED(bsel));
  vcb_bank #(.HOLD_CYCLES(16), .DYN_SIZING(1'b0)) u_dut_nodyn (.CLK(clk),
    .RESETN(resetn), .REQ(req), .RDATA(rdata2), .USER_STATUS(st),
    .USER_SET_EVENT(), .USER_CLEAR_EVENT(), .GEO_ADDR_N(geo),
    .SLAVE_WINDOW_MASK(mask), .FIXED_ADDRESS_FLAG(fixed),
    .BERR_DRIVEN(berr), .BACKPLANE_ADDRESS_LINES(bal),
    .LOCAL_RESET_N(), .FAIL_LINE_DRIVE_OUT(),
    .MODULE_ENABLED(), .BOARD_SELECTED());
  vcb_user_model u_user (.clk(clk), .resetn(resetn), .set_ev(sev),
    .clr_ev(cev), .status(st));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] base_of(input logic [4:0] g);
    return {~g, 27'h0};
  endfunction : base_of
  function automatic logic [31:0] bits(input int a, input int b2);
    return (32'h1 << a) | (32'h1 << b2);
  endfunction : bits
  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk);
    req <= '0;
    #1;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    #1;
    v = rdata;
  endtask : rd
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(n, e, v);
  endtask : rchk
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(1961));
    geo = 5'($urandom());
    mask = 24'($urandom());
    req = '0; fixed = 1'b0; berr = 1'b0; bal = 5'h0; resetn = 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    rchk("set_reg", OFF_STANDARD_BIT_SET, REG_RESET);
    rchk("clr_reg", OFF_STANDARD_BIT_CLEAR, REG_RESET);
    rchk("holder", OFF_CONFIG_RAM_HOLDER, REG_RESET);
    rchk("base", OFF_CONFIG_SPACE_BASE, base_of(geo));
    rchk("unmapped", 12'h100, 32'h0);
    chk("lrst_n", 32'h1, 32'(lrst_n));
    $display("test reset done");
    ust = 8'h00;
    for (int i = 0; i < 4; i++) begin
      b = 8'($urandom());
      wr(OFF_USER_PULSE_SET, {b, 24'hffffff});
      chk("set_ev", 32'(b), 32'(sev));
      @(posedge clk); #1;
      chk("set_ev_end", 32'h0, 32'(sev));
      ust = ust | b;
      rchk("user_set_rd", OFF_USER_PULSE_SET, {ust, 24'h0});
      b = 8'($urandom());
      wr(OFF_USER_PULSE_CLEAR, {b, 24'hffffff});
      chk("clr_ev", 32'(b), 32'(cev));
      @(posedge clk); #1;
      chk("clr_ev_end", 32'h0, 32'(cev));
      ust = ust & ~b;
      rchk("user_clr_rd", OFF_USER_PULSE_CLEAR, {ust, 24'h0});
    end
    $display("test user bits done");
    h = 8'($urandom_range(1, 255));
    wr(OFF_CONFIG_RAM_HOLDER, {h, 24'hffffff});
    rchk("holder_wr", OFF_CONFIG_RAM_HOLDER, {h, 24'h0});
    wr(OFF_CONFIG_RAM_HOLDER, {~h, 24'h0});
    rchk("holder_lock", OFF_CONFIG_RAM_HOLDER, {h, 24'h0});
    wr(OFF_STANDARD_BIT_SET, 32'h0400_0000);
    rchk("taken", OFF_STANDARD_BIT_SET, 32'h0400_0000);
    rchk("owned", OFF_STANDARD_BIT_CLEAR, 32'h0400_0000);
    wr(OFF_STANDARD_BIT_CLEAR, 32'h0400_0000);
    rchk("released", OFF_CONFIG_RAM_HOLDER, 32'h0);
    rchk("taken_off", OFF_STANDARD_BIT_SET, 32'h0);
    $display("test holder done");
    wr(OFF_STANDARD_BIT_SET, 32'hffff_ffff & ~bits(31, 26));
    chk("fail_men", 32'h3, {30'h0, fail, men});
    rchk("set_live", OFF_STANDARD_BIT_SET, 32'h5800_0000);
    wr(OFF_STANDARD_BIT_CLEAR, bits(30, 27) | bits(28, 28));
    chk("fail_men_off", 32'h0, {30'h0, fail, men});
    rchk("clr_live", OFF_STANDARD_BIT_CLEAR, 32'h0);
    @(posedge clk); berr <= 1'b1;
    @(posedge clk); berr <= 1'b0;
    rchk("berr", OFF_STANDARD_BIT_SET, 32'h0800_0000);
    wr(OFF_STANDARD_BIT_CLEAR, 32'h0800_0000);
    rchk("berr_clr", OFF_STANDARD_BIT_SET, 32'h0);
    $display("test status bits done");
    wr(OFF_STANDARD_BIT_SET, 32'h8000_0000);
    chk("lrst_on", 32'h0, 32'(lrst_n));
    wr(OFF_STANDARD_BIT_CLEAR, 32'h8000_0000);
    rchk("lrst_held", OFF_STANDARD_BIT_CLEAR, 32'h8000_0000);
    repeat (20) @(posedge clk);
    wr(OFF_STANDARD_BIT_CLEAR, 32'h8000_0000);
    @(posedge clk); #1;
    chk("lrst_off", 32'h1, 32'(lrst_n));
    $display("test local reset done");
    d = $urandom();
    wr(OFF_CONFIG_SPACE_BASE, d);
    rchk("base_wr", OFF_CONFIG_SPACE_BASE, d & 32'hf800_0000);
    bal <= d[31:27];
    repeat (3) @(posedge clk); #1;
    chk("bsel", 32'h1, 32'(bsel));
    bal <= d[31:27] ^ 5'h01;
    repeat (3) @(posedge clk); #1;
    chk("bsel_off", 32'h0, 32'(bsel));
    $display("test base done");
    c = 24'($urandom());
    wr(OFF_FUNCTION_COMPARE, {c, 8'hfd});
    rchk("cmp", OFF_FUNCTION_COMPARE, {c, 8'h00});
    wr(OFF_FUNCTION_COMPARE, {~c, 8'h02});
    rchk("dyn", OFF_FUNCTION_COMPARE, {mask, 8'h02});
    chk("nodyn", {~c, 8'h00}, rdata2);
    fixed <= 1'b1;
    wr(OFF_FUNCTION_COMPARE, {~c, 8'h00});
    rchk("fixed", OFF_FUNCTION_COMPARE, {c, 8'h00});
    fixed <= 1'b0;
    wr(OFF_FUNCTION_COMPARE, {c, 8'h00});
    rchk("restored", OFF_FUNCTION_COMPARE, {c, 8'h00});
    $display("test compare done");
    summarize();
  end
endmodule : tb_top
